//--- rtl/alarm_port_pkg.sv
package alarm_port_pkg;
  // Bus addresses as whole address bytes (7-bit address plus R/W bit)
  localparam logic [7:0] ADDR_WRITE = 8'h40;
  localparam logic [7:0] ADDR_READ = 8'h41;
  // Bit positions of the port byte
  localparam int BIT_POWER = 0;
  localparam int BIT_CRITICAL = 1;
  localparam int BIT_MAJOR = 2;
  localparam int BIT_MINOR = 3;
  localparam int BIT_MAJOR_SENSE = 4;
  localparam int BIT_MINOR_SENSE = 5;
  localparam int BIT_COLOUR = 6;
  localparam int BIT_SPARE = 7;
  // Power-up value of the port: everything high and inactive
  localparam logic [7:0] PORT_RESET = 8'hFF;
  // Host clock divider: half period of the bus clock in system cycles
  localparam int SCL_HALF_NS = 5000;
  localparam int CLK_NS = 10;
  localparam int SCL_HALF_CYCLES = (SCL_HALF_NS + CLK_NS - 1) / CLK_NS;
endpackage

//--- rtl/alarm_link_if.sv
interface alarm_link_if;
  logic scl;
  logic sda_host_oe;
  logic sda_dev_oe;
  // Open-drain wire: low while either end pulls
  logic sda;
  assign sda = !(sda_host_oe || sda_dev_oe);
  modport device (input scl, input sda, output sda_dev_oe);
  modport host (output scl, input sda, output sda_host_oe);
endinterface

//--- rtl/front_panel_alarm_port.sv
// How it works
// - all alarm signals active low
// - relay and LED outputs power up high, alarms off
// - answer address bytes 40 write, 41 read
// - host writes all ones after reset
// - bit 0 low drives power relay, LED
// - fan failure also lights power alarm
// - fault lamp lights power; only write clears
// - bit 1 low drives critical relay, LED
// - critical ignores external clear inputs
// - bit 2 falling sets major latch; clears
// - major LED follows bit 2 level
// - bit 3 falling sets minor latch; clears
// - minor LED follows bit 3 level
// - bit 4 reads major latch, inverted
// - bit 5 reads minor latch, inverted
// - bit 6 picks colour, yellow at reset
// - fitted colour jumper forces red
// - host writes one to bit 7
module front_panel_alarm_port (
  // System
  input wire logic CLK,
  input wire logic RST_N,
  // Bus link
  alarm_link_if.device LINK,
  // External alarm inputs, active low
  input wire logic FAN_FAIL_N,
  input wire logic SYSTEM_FAULT_LAMP_N,
  input wire logic MAJOR_CLEAR_N,
  input wire logic MINOR_CLEAR_N,
  input wire logic COLOUR_JUMPER_HEADER_N,
  // Relay and LED drives, active low; COLOUR_RED high for red
  output logic POWER_RELAY_N,
  output logic POWER_LED_N,
  output logic CRITICAL_RELAY_N,
  output logic CRITICAL_LED_N,
  output logic MAJOR_RELAY_N,
  output logic MAJOR_LED_N,
  output logic MINOR_RELAY_N,
  output logic MINOR_LED_N,
  output logic COLOUR_RED
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ADDR = 3'b001,
    S_ACK = 3'b010,
    S_WRITE = 3'b011,
    S_READ = 3'b100,
    S_RACK = 3'b101
  } phase_t;

  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [4:0] in_sync;
    logic scl_last;
    logic sda_last;
    phase_t phase;
    logic [3:0] bit_count;
    logic [7:0] shift;
    logic is_read;
    logic sda_oe;
    logic [7:0] port;
    logic power_lamp;
    logic major_latch;
    logic minor_latch;
    logic [4:0] pins;
  } state_t;

  state_t s;
  state_t next_s;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [7:0] read_byte;

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection on the synchronised link pins
  assign scl_rise = s.scl_sync[1] && !s.scl_last;
  assign scl_fall = !s.scl_sync[1] && s.scl_last;
  assign start_seen = s.scl_sync[1] && s.scl_last && s.sda_last && !s.sda_sync[1];
  assign stop_seen = s.scl_sync[1] && s.scl_last && !s.sda_last && s.sda_sync[1];

  // Read value: driven bits read back, sense bits show the latches
  always_comb begin
    read_byte = s.port;
    read_byte[alarm_port_pkg::BIT_MAJOR_SENSE] = !s.major_latch;
    read_byte[alarm_port_pkg::BIT_MINOR_SENSE] = !s.minor_latch;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_s = s;
    // Two flops on every outside input before any logic sees it
    next_s.scl_sync = {s.scl_sync[0], LINK.scl};
    next_s.sda_sync = {s.sda_sync[0], LINK.sda};
    next_s.pins = {FAN_FAIL_N, SYSTEM_FAULT_LAMP_N, MAJOR_CLEAR_N, MINOR_CLEAR_N,
                   COLOUR_JUMPER_HEADER_N};
    next_s.in_sync = s.pins;
    next_s.scl_last = s.scl_sync[1];
    next_s.sda_last = s.sda_sync[1];
    if (start_seen) begin
      next_s.phase = S_ADDR;
      next_s.bit_count = 4'h0;
      next_s.sda_oe = 1'b0;
    end else if (stop_seen) begin
      next_s.phase = S_IDLE;
      next_s.sda_oe = 1'b0;
    end else begin
      case (s.phase)
        S_ADDR, S_WRITE: begin
          if (scl_rise) begin
            next_s.shift = {s.shift[6:0], s.sda_sync[1]};
            next_s.bit_count = s.bit_count + 4'h1;
          end else if (scl_fall && s.bit_count == 4'h8) begin
            next_s.bit_count = 4'h0;
            if (s.phase == S_ADDR) begin
              if (s.shift == alarm_port_pkg::ADDR_WRITE ||
                  s.shift == alarm_port_pkg::ADDR_READ) begin
                next_s.is_read = s.shift[0];
                next_s.sda_oe = 1'b1;
                next_s.phase = S_ACK;
              end else begin
                next_s.phase = S_IDLE;
              end
            end else begin
              // Each written byte lands at once on the port
              next_s.port = s.shift;
              next_s.sda_oe = 1'b1;
              next_s.phase = S_ACK;
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            if (s.is_read) begin
              next_s.shift = read_byte;
              next_s.sda_oe = !read_byte[7];
              next_s.bit_count = 4'h1;
              next_s.phase = S_READ;
            end else begin
              next_s.sda_oe = 1'b0;
              next_s.phase = S_WRITE;
            end
          end
        end
        S_READ: begin
          if (scl_fall) begin
            if (s.bit_count == 4'h8) begin
              next_s.sda_oe = 1'b0;
              next_s.phase = S_RACK;
            end else begin
              next_s.sda_oe = !s.shift[7 - s.bit_count[2:0]];
              next_s.bit_count = s.bit_count + 4'h1;
            end
          end
        end
        S_RACK: begin
          // A master not-acknowledge ends the read; ack sends another byte
          if (scl_rise) begin
            next_s.phase = s.sda_sync[1] ? S_IDLE : S_ACK;
          end
        end
        default: begin
          next_s.phase = S_IDLE;
        end
      endcase
    end
    // Fault lamp input latches the power alarm; only a write of 1 clears it
    if (!s.in_sync[3]) begin
      next_s.power_lamp = 1'b1;
    end else if (next_s.port[0] && !s.port[0]) begin
      next_s.power_lamp = 1'b0;
    end else if (s.phase == S_WRITE && next_s.phase == S_ACK
                 && s.shift[alarm_port_pkg::BIT_POWER]) begin
      next_s.power_lamp = 1'b0;
    end
    // Relay latches: falling write sets, high write or clear input resets
    if (s.port[alarm_port_pkg::BIT_MAJOR] && !next_s.port[alarm_port_pkg::BIT_MAJOR]) begin
      next_s.major_latch = 1'b1;
    end else if (next_s.port[alarm_port_pkg::BIT_MAJOR] || !s.in_sync[2]) begin
      next_s.major_latch = 1'b0;
    end
    if (s.port[alarm_port_pkg::BIT_MINOR] && !next_s.port[alarm_port_pkg::BIT_MINOR]) begin
      next_s.minor_latch = 1'b1;
    end else if (next_s.port[alarm_port_pkg::BIT_MINOR] || !s.in_sync[1]) begin
      next_s.minor_latch = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; port starts high since the real part has no reset pin
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s <= '0;
      s.scl_sync <= 2'b11;
      s.sda_sync <= 2'b11;
      s.scl_last <= 1'b1;
      s.sda_last <= 1'b1;
      s.in_sync <= 5'h1F;
      s.pins <= 5'h1F;
      s.port <= alarm_port_pkg::PORT_RESET;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, low means on, except sda_dev_oe and COLOUR_RED, which act when high
  assign LINK.sda_dev_oe = s.sda_oe;
  assign POWER_RELAY_N = s.port[0] && s.in_sync[4] && !s.power_lamp;
  assign POWER_LED_N = s.port[0] && s.in_sync[4] && !s.power_lamp;
  assign CRITICAL_RELAY_N = s.port[alarm_port_pkg::BIT_CRITICAL];
  assign CRITICAL_LED_N = s.port[alarm_port_pkg::BIT_CRITICAL];
  assign MAJOR_RELAY_N = !s.major_latch;
  assign MAJOR_LED_N = s.port[alarm_port_pkg::BIT_MAJOR];
  assign MINOR_RELAY_N = !s.minor_latch;
  assign MINOR_LED_N = s.port[alarm_port_pkg::BIT_MINOR];
  assign COLOUR_RED = !s.port[alarm_port_pkg::BIT_COLOUR] || !s.in_sync[0];
endmodule

//--- rtl/alarm_port_host.sv
module alarm_port_host (
  // System
  input wire logic CLK,
  input wire logic RST_N,
  // Bus link
  alarm_link_if.host LINK,
  // Command: write data or read the port
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic REQ_READ,
  input wire logic [7:0] REQ_DATA,
  // Answer
  output logic DONE,
  output logic ACK_OK,
  output logic [7:0] READ_DATA
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_START = 3'b001,
    H_BITS = 3'b010,
    H_STOP = 3'b011,
    H_END = 3'b100
  } hstate_t;

  typedef struct packed {
    hstate_t st;
    logic [15:0] div;
    logic phase;
    logic [4:0] idx;
    logic [17:0] frame;
    logic [17:0] got;
    logic scl;
    logic oe;
    logic rd;
    logic [1:0] sda_sync;
    logic done;
    logic ack_ok;
    logic [7:0] rdata;
  } hs_t;

  hs_t h;
  hs_t next_h;
  logic tick;
  logic [7:0] wbyte;

  assign tick = h.div == 16'(alarm_port_pkg::SCL_HALF_CYCLES - 1);
  // Sense and spare bits are always written as one
  assign wbyte = REQ_DATA | 8'hB0;

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencer: address, ack, data, ack, one bit per two half periods
  always_comb begin
    next_h = h;
    next_h.done = 1'b0;
    next_h.sda_sync = {h.sda_sync[0], LINK.sda};
    next_h.div = tick ? 16'h0000 : h.div + 16'h0001;
    case (h.st)
      H_IDLE: begin
        next_h.div = 16'h0000;
        if (REQ_VALID) begin
          next_h.rd = REQ_READ;
          next_h.frame = {REQ_READ ? alarm_port_pkg::ADDR_READ : alarm_port_pkg::ADDR_WRITE,
                          1'b1, REQ_READ ? 8'hFF : wbyte, 1'b1};
          next_h.oe = 1'b1;
          next_h.st = H_START;
        end
      end
      H_START: begin
        if (tick) begin
          next_h.scl = 1'b0;
          next_h.idx = 5'h00;
          next_h.phase = 1'b0;
          next_h.oe = !h.frame[17];
          next_h.st = H_BITS;
        end
      end
      H_BITS: begin
        if (tick) begin
          next_h.phase = !h.phase;
          next_h.scl = !h.phase;
          if (!h.phase) begin
            next_h.got = {h.got[16:0], h.sda_sync[1]};
          end else if (h.idx == 5'd17) begin
            next_h.oe = 1'b1;
            next_h.st = H_STOP;
          end else begin
            next_h.idx = h.idx + 5'h01;
            // Master drives its bits; final read ack is a not-acknowledge
            next_h.oe = !h.frame[16 - h.idx];
          end
        end
      end
      H_STOP: begin
        if (tick) begin
          next_h.scl = 1'b1;
          next_h.st = H_END;
        end
      end
      H_END: begin
        if (tick) begin
          next_h.oe = 1'b0;
          next_h.done = 1'b1;
          next_h.ack_ok = !h.got[9] && (h.rd || !h.got[0]);
          next_h.rdata = h.got[8:1];
          next_h.st = H_IDLE;
        end
      end
      default: begin
        next_h.st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      h <= '0;
      h.scl <= 1'b1;
      h.sda_sync <= 2'b11;
    end else begin
      h <= next_h;
    end
  end

  assign LINK.scl = h.scl;
  assign LINK.sda_host_oe = h.oe;
  assign REQ_READY = h.st == H_IDLE;
  assign DONE = h.done;
  assign ACK_OK = h.ack_ok;
  assign READ_DATA = h.rdata;
endmodule

//--- verif/front_panel_alarm_port_properties.sv
module front_panel_alarm_port_properties (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Link wires
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_dev_oe,
  // Alarm inputs
  input wire logic FAN_FAIL_N,
  input wire logic MAJOR_CLEAR_N,
  input wire logic MINOR_CLEAR_N,
  input wire logic COLOUR_JUMPER_HEADER_N,
  // Alarm outputs
  input wire logic POWER_RELAY_N,
  input wire logic POWER_LED_N,
  input wire logic CRITICAL_RELAY_N,
  input wire logic CRITICAL_LED_N,
  input wire logic MAJOR_RELAY_N,
  input wire logic MAJOR_LED_N,
  input wire logic MINOR_RELAY_N,
  input wire logic MINOR_LED_N,
  input wire logic COLOUR_RED
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////////////////////////
  // Start on the wire, and clears held while the bus clock rests high
  sequence start_s;
    scl && $fell(sda);
  endsequence
  sequence major_clear_s;
    (!MAJOR_CLEAR_N && scl) [*8];
  endsequence
  sequence minor_clear_s;
    (!MINOR_CLEAR_N && scl) [*8];
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  // Input paths allow for the two resync flops plus the state register
  fan_power_a: assert property ((!FAN_FAIL_N) [*6] |-> !POWER_RELAY_N && !POWER_LED_N)
    else $error("fan failure did not light power alarm");
  led_pairs_a: assert property (POWER_LED_N == POWER_RELAY_N
      && CRITICAL_LED_N == CRITICAL_RELAY_N)
    else $error("relay and led disagree");
  critical_write_a: assert property ($changed(CRITICAL_RELAY_N) |-> !scl)
    else $error("critical alarm changed outside a write");
  led_bits_a: assert property ($changed(MAJOR_LED_N) || $changed(MINOR_LED_N) |-> !scl)
    else $error("major or minor led changed outside a write");
  major_clear_a: assert property (major_clear_s |-> MAJOR_RELAY_N)
    else $error("major clear input ignored");
  minor_clear_a: assert property (minor_clear_s |-> MINOR_RELAY_N)
    else $error("minor clear input ignored");
  jumper_red_a: assert property ((!COLOUR_JUMPER_HEADER_N) [*6] |-> COLOUR_RED)
    else $error("colour jumper did not force red");
  device_data_a: assert property ($changed(sda_dev_oe) |-> !scl)
    else $error("device moved data while bus clock high");
  host_start_a: assert property (start_s |-> !sda_dev_oe)
    else $error("device pulling data at start");
endmodule

//--- verif/front_panel_alarm_port_bench.sv
module front_panel_alarm_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic rst_n;
  logic fan_n;
  logic lamp_n;
  logic mjclr_n;
  logic mnclr_n;
  logic jmp_n;
  logic req_valid;
  logic req_read;
  logic [7:0] req_data;
  logic req_ready;
  logic done;
  logic ack_ok;
  logic [7:0] read_data;
  logic [7:0] addr_seen;
  wire logic [8:0] outs;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  alarm_link_if lnk ();
  ////////////////////////////////////////////////////////////////////////////////
  // Both ends joined over one link, checker beside it
  front_panel_alarm_port u_front_panel_alarm_port (
    .CLK(clk), .RST_N(rst_n), .LINK(lnk), .FAN_FAIL_N(fan_n),
    .SYSTEM_FAULT_LAMP_N(lamp_n), .MAJOR_CLEAR_N(mjclr_n), .MINOR_CLEAR_N(mnclr_n),
    .COLOUR_JUMPER_HEADER_N(jmp_n), .POWER_RELAY_N(outs[0]), .POWER_LED_N(outs[1]),
    .CRITICAL_RELAY_N(outs[2]), .CRITICAL_LED_N(outs[3]), .MAJOR_RELAY_N(outs[4]),
    .MAJOR_LED_N(outs[5]), .MINOR_RELAY_N(outs[6]), .MINOR_LED_N(outs[7]),
    .COLOUR_RED(outs[8]));
  alarm_port_host u_alarm_port_host (
    .CLK(clk), .RST_N(rst_n), .LINK(lnk), .REQ_VALID(req_valid), .REQ_READY(req_ready),
    .REQ_READ(req_read), .REQ_DATA(req_data), .DONE(done), .ACK_OK(ack_ok),
    .READ_DATA(read_data));
  front_panel_alarm_port_properties u_front_panel_alarm_port_properties (
    .CLK(clk), .RST_N(rst_n), .scl(lnk.scl), .sda(lnk.sda), .sda_dev_oe(lnk.sda_dev_oe),
    .FAN_FAIL_N(fan_n), .MAJOR_CLEAR_N(mjclr_n), .MINOR_CLEAR_N(mnclr_n),
    .COLOUR_JUMPER_HEADER_N(jmp_n), .POWER_RELAY_N(outs[0]), .POWER_LED_N(outs[1]),
    .CRITICAL_RELAY_N(outs[2]), .CRITICAL_LED_N(outs[3]), .MAJOR_RELAY_N(outs[4]),
    .MAJOR_LED_N(outs[5]), .MINOR_RELAY_N(outs[6]), .MINOR_LED_N(outs[7]),
    .COLOUR_RED(outs[8]));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, and a cycle ceiling sized for four frames of about 20000 cycles
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 95000) begin
      fail_count++;
      end_of_test();
    end
  end
  // First byte after a start, sampled on rising bus clock, MSB first
  initial begin
    @(negedge lnk.sda iff lnk.scl === 1'b1);
    repeat (8) @(posedge lnk.scl) addr_seen = {addr_seen[6:0], lnk.sda};
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and bus tasks
  task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Request held until taken; results stand after the done pulse
  task automatic xfer(input logic rd, input logic [7:0] d);
    @(negedge clk);
    req_valid = 1'b1;
    req_read = rd;
    req_data = d;
    @(posedge clk iff req_ready === 1'b1);
    @(negedge clk);
    req_valid = 1'b0;
    for (int n = 0; n < 30000 && done !== 1'b1; n++) @(negedge clk);
    check("done", {8'h00, done}, 9'h001);
    check("ack", {8'h00, ack_ok}, 9'h001);
  endtask
  // Long enough for the resync flops to pass the level
  task automatic hold(ref logic sig, input logic v);
    sig = v;
    repeat (10) @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n = 1'b0;
    {fan_n, lamp_n, mjclr_n, mnclr_n, jmp_n} = 5'h1F;
    req_valid = 1'b0;
    req_read = 1'b0;
    req_data = 8'hFF;
    repeat (20) @(negedge clk);
    check("reset outs", outs, 9'h0FF);
    rst_n = 1'b1;
    @(negedge clk);
    check("idle wire", {7'h00, lnk.scl, lnk.sda}, 9'h003);
    // Software opens every run with all ones, the port keeps no reset of its own
    xfer(1'b0, 8'hFF);
    check("address byte", {1'b0, addr_seen}, 9'h040);
    check("alarms off", outs, 9'h0FF);
    hold(fan_n, 1'b0);
    check("fan fail", outs, 9'h0FC);
    hold(fan_n, 1'b1);
    hold(lamp_n, 1'b0);
    hold(lamp_n, 1'b1);
    hold(jmp_n, 1'b0);
    check("lamp held red", outs, 9'h1FC);
    hold(jmp_n, 1'b1);
    // Lamp stays latched through this write since bit 0 goes low
    xfer(1'b0, 8'hB0);
    check("alarms on", outs, 9'h100);
    hold(mjclr_n, 1'b0);
    hold(mjclr_n, 1'b1);
    check("major cleared", outs, 9'h110);
    xfer(1'b1, 8'hFF);
    check("read port", {1'b0, read_data}, 9'h090);
    hold(mnclr_n, 1'b0);
    hold(mnclr_n, 1'b1);
    check("minor cleared", outs, 9'h150);
    xfer(1'b0, 8'hFF);
    check("lamp cleared", outs, 9'h0FF);
    end_of_test();
  end
endmodule
